// [expander_cfg.svh]
// Constants of the two-wire I/O expander: address, pointer codes, reset values.
// Assumes inclusion by bare name from the design file that needs them.
`ifndef EXPANDER_CFG_SVH
`define EXPANDER_CFG_SVH
`define EXP_ADDR_FIXED  4'h3
`define EXP_RW_READ     1'h1
`define EXP_PTR_INPUT   2'h0
`define EXP_PTR_OUTPUT  2'h1
`define EXP_PTR_INVERT  2'h2
`define EXP_PTR_DIR     2'h3
`define EXP_RST_OUTPUT  8'h00
`define EXP_RST_INVERT  8'hf0
`define EXP_RST_DIR     8'hff
`define EXP_RST_POINTER 8'h00
`define EXP_ACK_SLOT    4'h8
`define EXP_BIT_ONE     4'h1
`define EXP_BIT_FIRST   4'h0
`endif

// [expander_pkg.sv]
// Types shared by the two-wire I/O expander design.
// Assumes nothing of its surroundings.
`default_nettype none
package expander_pkg;
   // Frame sequencer states on the serial clock
   typedef enum logic [2:0] {
      ST_ADDR   = 3'b000,
      ST_CMD    = 3'b001,
      ST_WDATA  = 3'b010,
      ST_RDATA  = 3'b011,
      ST_IGNORE = 3'b100
   } link_state_t;
endpackage
`default_nettype wire

// [i2c_port_expander_regs.sv]
// Two-wire slave and register file of an 8-bit remote I/O expander.
// Assumes the serial clock pin is routed as a clock; open-drain pins are resolved outside.
`timescale 1ns/1ns
`default_nettype none
`include "expander_cfg.svh"

module i2c_port_expander_regs (
   // System clock and reset
   input  wire logic       i_clock,
   input  wire logic       i_reset_n,
   // Serial link: clock from the master, open-drain data
   input  wire logic       i_scl_clock,
   input  wire logic       i_sda,
   output logic            o_sda,
   output logic            o_sda_oe,
   // Address straps
   input  wire logic [2:0] i_addr_strap,
   // Port pins
   input  wire logic [7:0] i_port_pins,
   output logic      [7:0] o_port_pins,
   output logic      [7:0] o_port_pins_oe,
   // Open-drain change alert, active low on the wire
   output logic            o_alert_n,
   output logic            o_alert_n_oe
);

   // ---------------- System domain: frame framing and change alert ----------------
   logic       scl_s1_q, scl_s2_q, scl_p_q;
   logic       sda_s1_q, sda_s2_q, sda_p_q;
   logic       link_rst_q, link_rst_d;
   logic       start_pend_q, start_pend_d;
   logic [7:0] pin_a1_q, pin_a2_q;
   logic [7:0] dir_a1_q, dir_a2_q;
   logic       clr_t1_q, clr_t2_q, clr_t3_q;
   logic [7:0] ref_q, ref_d;
   logic [2:0] ref_arm_q;
   logic       alert_q, alert_d;
   logic       start_det, stop_det, clr_pulse;

   // Link-domain state read by the system domain
   logic [7:0] dir_q;
   logic       clr_tog_q;

   // Start and stop are edges of data while the clock is high
   always_comb begin
      start_det    = scl_s2_q && scl_p_q && sda_p_q && !sda_s2_q;
      stop_det     = scl_s2_q && scl_p_q && !sda_p_q && sda_s2_q;
      start_pend_d = start_pend_q;
      link_rst_d   = link_rst_q;
      if (stop_det) begin
         link_rst_d   = 1'b1;
         start_pend_d = 1'b0;
      end else if (start_det) begin
         link_rst_d   = 1'b1;
         start_pend_d = 1'b1;
      end else if (start_pend_q && !scl_s2_q) begin
         // Sequencer leaves reset while the clock is low, well ahead of the next rising edge
         link_rst_d   = 1'b0;
         start_pend_d = 1'b0;
      end
   end

   // Alert compares input pins against the levels seen at the last clear
   always_comb begin
      clr_pulse = clr_t2_q ^ clr_t3_q;
      ref_d     = ref_q;
      if (!ref_arm_q[2] || clr_pulse) begin
         ref_d = pin_a2_q;
      end
      alert_d = |((pin_a2_q ^ ref_d) & dir_a2_q);
   end

   // System-domain registers; each first synchroniser stage feeds only its second
   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         scl_s1_q     <= 1'b1;
         scl_s2_q     <= 1'b1;
         scl_p_q      <= 1'b1;
         sda_s1_q     <= 1'b1;
         sda_s2_q     <= 1'b1;
         sda_p_q      <= 1'b1;
         link_rst_q   <= 1'b1;
         start_pend_q <= 1'b0;
         pin_a1_q     <= `EXP_RST_OUTPUT;
         pin_a2_q     <= `EXP_RST_OUTPUT;
         dir_a1_q     <= `EXP_RST_DIR;
         dir_a2_q     <= `EXP_RST_DIR;
         clr_t1_q     <= 1'b0;
         clr_t2_q     <= 1'b0;
         clr_t3_q     <= 1'b0;
         ref_q        <= `EXP_RST_OUTPUT;
         ref_arm_q    <= 3'h0;
         alert_q      <= 1'b0;
      end else begin
         scl_s1_q     <= i_scl_clock;
         scl_s2_q     <= scl_s1_q;
         scl_p_q      <= scl_s2_q;
         sda_s1_q     <= i_sda;
         sda_s2_q     <= sda_s1_q;
         sda_p_q      <= sda_s2_q;
         link_rst_q   <= link_rst_d;
         start_pend_q <= start_pend_d;
         pin_a1_q     <= i_port_pins;
         pin_a2_q     <= pin_a1_q;
         dir_a1_q     <= dir_q;          // Bits used one by one, so a mixed sample is harmless
         dir_a2_q     <= dir_a1_q;
         clr_t1_q     <= clr_tog_q;
         clr_t2_q     <= clr_t1_q;
         clr_t3_q     <= clr_t2_q;
         ref_q        <= ref_d;
         ref_arm_q    <= {ref_arm_q[1:0], 1'b1};  // Track pins until the synchroniser is full
         alert_q      <= alert_d;
      end
   end

   // ---------------- Link domain: serial sequencer on the master's clock ----------------
   logic                      link_arst_n;
   expander_pkg::link_state_t state_q, state_d;
   logic [3:0]                cnt_q, cnt_d;
   logic [7:0]                shift_q, shift_d;
   logic [6:0]                own_addr;
   logic                      addr_match;

   logic [2:0] strap_s1_q, strap_s2_q;
   logic [7:0] pin_l1_q, pin_l2_q;
   logic [7:0] pointer_q, pointer_d;
   logic [7:0] out_q, out_d;
   logic [7:0] inv_q, inv_d;
   logic [7:0] dir_d;
   logic [7:0] port_oe_q;
   logic       clr_tog_d;
   logic [7:0] rd_byte;

   // Stop, start and the external reset all put the sequencer back to its default
   assign link_arst_n = i_reset_n & ~link_rst_q;

   // Own address from fixed upper bits and straps
   always_comb begin
      own_addr   = {`EXP_ADDR_FIXED, strap_s2_q};
      addr_match = (shift_q[7:1] == own_addr);
   end

   // Next sequencer state; bits shift in on rising edges, ninth bit is the acknowledge
   always_comb begin
      state_d = state_q;
      cnt_d   = cnt_q;
      shift_d = shift_q;
      if (cnt_q != `EXP_ACK_SLOT) begin
         shift_d = {shift_q[6:0], i_sda};
         cnt_d   = cnt_q + `EXP_BIT_ONE;
      end else begin
         cnt_d = `EXP_BIT_FIRST;
         case (state_q)
            expander_pkg::ST_ADDR: begin
               if (!addr_match) begin
                  state_d = expander_pkg::ST_IGNORE;
               end else if (shift_q[0] == `EXP_RW_READ) begin
                  state_d = expander_pkg::ST_RDATA;
               end else begin
                  state_d = expander_pkg::ST_CMD;
               end
            end
            expander_pkg::ST_CMD: begin
               state_d = expander_pkg::ST_WDATA;
            end
            expander_pkg::ST_WDATA: begin
               state_d = expander_pkg::ST_WDATA;
            end
            expander_pkg::ST_RDATA: begin
               // Master's not-acknowledge ends the read; wait for stop or restart
               state_d = i_sda ? expander_pkg::ST_IGNORE : expander_pkg::ST_RDATA;
            end
            expander_pkg::ST_IGNORE: begin
               state_d = expander_pkg::ST_IGNORE;
            end
            default: begin
               state_d = expander_pkg::ST_IGNORE;
            end
         endcase
      end
   end

   // Sequencer registers, cleared by any start or stop
   always_ff @(posedge i_scl_clock or negedge link_arst_n) begin
      if (!link_arst_n) begin
         state_q <= expander_pkg::ST_ADDR;
         cnt_q   <= `EXP_BIT_FIRST;
         shift_q <= `EXP_RST_POINTER;
      end else begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
         shift_q <= shift_d;
      end
   end

   // Read data mux; inversion applies to the reported level of every pin
   always_comb begin
      case (pointer_q[1:0])
         `EXP_PTR_INPUT:  rd_byte = pin_l2_q ^ inv_q;
         `EXP_PTR_OUTPUT: rd_byte = out_q;
         `EXP_PTR_INVERT: rd_byte = inv_q;
         `EXP_PTR_DIR:    rd_byte = dir_q;
         default:         rd_byte = out_q;
      endcase
   end

   // Register file writes happen only on the acknowledge rising edge
   always_comb begin
      pointer_d = pointer_q;
      out_d     = out_q;
      inv_d     = inv_q;
      dir_d     = dir_q;
      clr_tog_d = clr_tog_q;
      if (cnt_q == `EXP_ACK_SLOT) begin
         case (state_q)
            expander_pkg::ST_CMD: begin
               pointer_d = shift_q;
            end
            expander_pkg::ST_WDATA: begin
               // Same pointer for every byte; an unfinished byte never lands
               case (pointer_q[1:0])
                  `EXP_PTR_OUTPUT: out_d = shift_q;
                  `EXP_PTR_INVERT: inv_d = shift_q;
                  `EXP_PTR_DIR:    dir_d = shift_q;
                  default:         out_d = out_q;
               endcase
            end
            expander_pkg::ST_RDATA: begin
               if (pointer_q[1:0] == `EXP_PTR_INPUT) begin
                  clr_tog_d = ~clr_tog_q;
               end
            end
            default: begin
               pointer_d = pointer_q;
            end
         endcase
      end
   end

   // Register file survives start and stop; only the external reset clears it
   always_ff @(posedge i_scl_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         strap_s1_q <= 3'h0;
         strap_s2_q <= 3'h0;
         pin_l1_q   <= `EXP_RST_OUTPUT;
         pin_l2_q   <= `EXP_RST_OUTPUT;
         pointer_q  <= `EXP_RST_POINTER;
         out_q      <= `EXP_RST_OUTPUT;
         inv_q      <= `EXP_RST_INVERT;
         dir_q      <= `EXP_RST_DIR;
         port_oe_q  <= ~`EXP_RST_DIR;
         clr_tog_q  <= 1'b0;
      end else begin
         strap_s1_q <= i_addr_strap;
         strap_s2_q <= strap_s1_q;
         pin_l1_q   <= i_port_pins;
         pin_l2_q   <= pin_l1_q;
         pointer_q  <= pointer_d;
         out_q      <= out_d;
         inv_q      <= inv_d;
         dir_q      <= dir_d;
         port_oe_q  <= ~dir_d;
         clr_tog_q  <= clr_tog_d;
      end
   end

   // ---------------- Link domain: data line driver on falling edges ----------------
   logic [7:0] tx_q, tx_d;
   logic       sda_oe_q, sda_oe_d;

   // Data changes only while the clock is low, so it never mimics start or stop
   always_comb begin
      tx_d     = tx_q;
      sda_oe_d = 1'b0;
      if (cnt_q == `EXP_ACK_SLOT) begin
         if ((state_q == expander_pkg::ST_ADDR && addr_match) ||
             state_q == expander_pkg::ST_CMD || state_q == expander_pkg::ST_WDATA) begin
            sda_oe_d = 1'b1;
         end
      end else if (state_q == expander_pkg::ST_RDATA) begin
         if (cnt_q == `EXP_BIT_FIRST) begin
            tx_d = rd_byte;
         end else begin
            tx_d = {tx_q[6:0], 1'b0};
         end
         sda_oe_d = ~tx_d[7];               // Low bits pull, high bits release
      end
   end

   // Driver registers
   always_ff @(negedge i_scl_clock or negedge link_arst_n) begin
      if (!link_arst_n) begin
         tx_q     <= `EXP_RST_POINTER;
         sda_oe_q <= 1'b0;
      end else begin
         tx_q     <= tx_d;
         sda_oe_q <= sda_oe_d;
      end
   end

   // Open-drain pins only ever drive low
   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_sda     <= 1'b0;
         o_alert_n <= 1'b0;
      end else begin
         o_sda     <= 1'b0;
         o_alert_n <= 1'b0;
      end
   end

   assign o_sda_oe       = sda_oe_q;
   assign o_port_pins    = out_q;
   assign o_port_pins_oe = port_oe_q;
   assign o_alert_n_oe   = alert_q;

endmodule

`default_nettype wire

// [exp_master.sv]
// Behavioural two-wire bus master for the expander's serial pins.
// Assumes the bench resolves the data wire with a pull-up.
`timescale 1ns/1ns
`default_nettype none
module exp_master (
   // Serial pins
   output logic      o_scl,
   output logic      o_sda_low,
   input  wire logic i_sda
);
   logic r;
   // Clock stands high between frames; data wire released
   initial begin
      o_scl = 1'b1;
      o_sda_low = 1'b0;
   end
   // Data moves well after the fall so no false start or stop is seen
   task automatic bit1(input logic b);
      #4 o_sda_low = ~b;
      #12 o_scl = 1'b1;
      r = i_sda;
      #16 o_scl = 1'b0;
   endtask
   // Start, or repeated start from inside a frame
   task automatic start();
      if (!o_scl) begin
         #4 o_sda_low = 1'b0;
         #12 o_scl = 1'b1;
      end
      #121 o_sda_low = 1'b1;
      #121 o_scl = 1'b0;
      #100;
   endtask
   task automatic stop();
      #4 o_sda_low = 1'b1;
      #100 o_scl = 1'b1;
      #121 o_sda_low = 1'b0;
      #121;
   endtask
   // Byte out, MSB first, then the device's answer bit
   task automatic wr(input logic [7:0] d, output logic ack);
      for (int i = 7; i >= 0; i--) bit1(d[i]);
      bit1(1'b1);
      ack = ~r;
   endtask
   // Byte in; the last one is not acknowledged
   task automatic rd(input logic last, output logic [7:0] d);
      for (int i = 7; i >= 0; i--) begin
         bit1(1'b1);
         d[i] = r;
      end
      bit1(last);
   endtask
endmodule
`default_nettype wire

// [i2c_port_expander_regs_asserts.sv]
// Port-level checks of the I/O expander.
// Assumes binding to the expander's top module; all checks on the system clock.
`timescale 1ns/1ns
`default_nettype none
module i2c_port_expander_regs_asserts (
   // Clock and reset
   input wire logic       i_clock,
   input wire logic       i_reset_n,
   // Link and pins
   input wire logic       i_scl_clock,
   input wire logic [7:0] i_port_pins,
   input wire logic       o_sda,
   input wire logic       o_sda_oe,
   input wire logic [7:0] o_port_pins,
   input wire logic [7:0] o_port_pins_oe,
   input wire logic       o_alert_n,
   input wire logic       o_alert_n_oe
);
   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (!i_reset_n);
   // Open-drain outputs may only pull low
   AST_SDA_PULL_ONLY: assert property (o_sda_oe |-> !o_sda)
      else $error("data wire driven high");
   AST_ALERT_PULL_ONLY: assert property (o_alert_n_oe |-> !o_alert_n)
      else $error("alert driven high");
   // Data drive moves only on a serial clock fall, so it is stable while high
   AST_SDA_AT_FALL: assert property ($changed(o_sda_oe) |-> !i_scl_clock && $past(i_scl_clock))
      else $error("data drive moved outside a clock fall");
   // Latch and direction land on the rising serial clock of the acknowledge
   AST_PINS_AT_RISE: assert property ($changed(o_port_pins) |-> i_scl_clock && !$past(i_scl_clock))
      else $error("latch moved outside a clock rise");
   AST_DIR_AT_RISE: assert property ($changed(o_port_pins_oe) |-> i_scl_clock && !$past(i_scl_clock))
      else $error("direction moved outside a clock rise");
   AST_RESET_STATE: assert property ($rose(i_reset_n) |-> o_port_pins_oe == 8'h00 && !o_sda_oe)
      else $error("outputs not at defaults after reset");
   // Alert needs a recent pin edge; lag is a few cycles
   AST_ALERT_CAUSE: assert property ($rose(o_alert_n_oe) |-> i_port_pins != $past(i_port_pins, 8))
      else $error("alert without pin change");
   // A long high clock means start, stop or idle: the device is off the wire
   AST_IDLE_RELEASED: assert property (i_scl_clock [*8] |-> !o_sda_oe)
      else $error("data wire held outside a frame");
   COV_ALERT: cover property ($rose(o_alert_n_oe));
   COV_ACK: cover property ($rose(o_sda_oe));
   COV_DIR: cover property ($changed(o_port_pins_oe));
endmodule
`default_nettype wire

// [tb_i2c_port_expander_regs.sv]
// Self-checking bench of the I/O expander with a behavioural bus master.
// Assumes pull-ups on the data wire; port pins resolved from drive enables.
`timescale 1ns/1ns
`default_nettype none
module tb_i2c_port_expander_regs;
   localparam logic [6:0] ADDR = 7'h1d;
   logic       clock, reset_n, scl, m_low, sda, sda_out, sda_oe, al, al_oe;
   logic [2:0] strap;
   logic [7:0] ext, pins, o_pins, o_oe;
   int         n_errors, n_tests, cyc;
   // Wires resolved from every party's enables
   assign sda = !(m_low || sda_oe);
   assign pins = (o_oe & o_pins) | (~o_oe & ext);
   i2c_port_expander_regs i_dut (
      .i_clock(clock), .i_reset_n(reset_n), .i_scl_clock(scl), .i_sda(sda),
      .o_sda(sda_out), .o_sda_oe(sda_oe), .i_addr_strap(strap), .i_port_pins(pins),
      .o_port_pins(o_pins), .o_port_pins_oe(o_oe), .o_alert_n(al), .o_alert_n_oe(al_oe));
   exp_master u_mst (.o_scl(scl), .o_sda_low(m_low), .i_sda(sda));
   always #4 clock = ~clock;
   // Cycle count for the hang guard, far above the expected run
   always @(posedge clock) begin
      cyc <= cyc + 1;
   end
   task automatic end_of_test();
      $display("errors %0d tests %0d", n_errors, n_tests);
      if (n_errors == 0 && n_tests > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, exp);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic xw(input logic [7:0] d, input logic a);
      logic k;
      u_mst.wr(d, k);
      chk({7'h00, k}, {7'h00, a});
   endtask
   task automatic set_ext(input logic [7:0] v);
      @(posedge clock);
      ext <= v;
      repeat (10) @(posedge clock);
   endtask
   task automatic do_reset();
      @(posedge clock);
      reset_n <= 1'b0;
      repeat (12) @(posedge clock);
      reset_n <= 1'b1;
      repeat (4) @(posedge clock);
   endtask
   task automatic set_reg(input logic [7:0] p, d);
      u_mst.start();
      xw({ADDR, 1'b0}, 1'b1);
      xw(p, 1'b1);
      xw(d, 1'b1);
      u_mst.stop();
   endtask
   // Optional pointer write, then n bytes read back
   task automatic get_reg(input logic wp, input logic [7:0] p, e, input int n);
      logic [7:0] d;
      u_mst.start();
      if (wp) begin
         xw({ADDR, 1'b0}, 1'b1);
         xw(p, 1'b1);
         u_mst.start();
      end
      xw({ADDR, 1'b1}, 1'b1);
      for (int i = 0; i < n; i++) begin
         u_mst.rd(i == n - 1, d);
         chk(d, e);
      end
      u_mst.stop();
   endtask
   task automatic t_defaults();
      chk(o_oe, 8'h00);
      chk({7'h00, al_oe}, 8'h00);
      get_reg(1'b1, 8'h01, 8'h00, 1);
      get_reg(1'b1, 8'h02, 8'hf0, 1);
      get_reg(1'b1, 8'h03, 8'hff, 1);
   endtask
   task automatic t_addr();
      for (int s = 0; s < 8; s++) begin
         @(posedge clock);
         strap <= s[2:0];
         u_mst.start();
         xw({4'h3, s[2:0], 1'b0}, 1'b1);
         u_mst.stop();
         u_mst.start();
         xw({4'h3, ~s[2:0], 1'b0}, 1'b0);
         xw(8'h01, 1'b0);
         u_mst.stop();
      end
      @(posedge clock);
      strap <= 3'h5;
   endtask
   // Two data bytes in one write land in the same register
   task automatic t_write();
      set_ext(8'h3c);
      u_mst.start();
      xw({ADDR, 1'b0}, 1'b1);
      xw(8'h01, 1'b1);
      xw(8'h11, 1'b1);
      xw(8'h5a, 1'b1);
      u_mst.stop();
      set_reg(8'h03, 8'h0f);
      chk(o_oe, 8'hf0);
      chk(pins, 8'h5c);
      get_reg(1'b1, 8'h01, 8'h5a, 1);
      get_reg(1'b1, 8'h03, 8'h0f, 1);
   endtask
   task automatic t_input();
      set_reg(8'h02, 8'h03);
      set_reg(8'h00, 8'hff);
      get_reg(1'b1, 8'h00, 8'h5f, 2);
      get_reg(1'b0, 8'h00, 8'h5f, 1);
      get_reg(1'b1, 8'h01, 8'h5a, 1);
   endtask
   task automatic t_alert();
      chk({7'h00, al_oe}, 8'h00);
      set_ext(8'h3d);
      chk({7'h00, al_oe}, 8'h01);
      set_ext(8'h3c);
      chk({7'h00, al_oe}, 8'h00);
      set_reg(8'h01, 8'ha5);
      repeat (10) @(posedge clock);
      chk({7'h00, al_oe}, 8'h00);
      set_ext(8'h3e);
      chk({7'h00, al_oe}, 8'h01);
      get_reg(1'b1, 8'h00, 8'had, 1);
      chk({7'h00, al_oe}, 8'h00);
   endtask
   // Stop in mid-byte keeps the last acknowledged data
   task automatic t_stop();
      u_mst.start();
      xw({ADDR, 1'b0}, 1'b1);
      xw(8'h01, 1'b1);
      xw(8'h3c, 1'b1);
      for (int i = 0; i < 4; i++) u_mst.bit1(1'b0);
      u_mst.stop();
      get_reg(1'b1, 8'h01, 8'h3c, 1);
   endtask
   initial begin
      clock = 1'b0;
      reset_n = 1'b0;
      strap = 3'h5;
      ext = 8'h00;
      n_errors = 0;
      n_tests = 0;
      // Scenarios race the guard; a hang counts as a mismatch
      fork
         begin
            do_reset();
            t_defaults();
            t_addr();
            t_write();
            t_input();
            t_alert();
            t_stop();
            do_reset();
            t_defaults();
         end
         wait (cyc >= 40000);
      join_any
      if (cyc >= 40000) begin
         n_errors++;
      end
      end_of_test();
   end
endmodule
bind i2c_port_expander_regs i2c_port_expander_regs_asserts u_asserts (
   .i_clock, .i_reset_n, .i_scl_clock, .i_port_pins, .o_sda, .o_sda_oe,
   .o_port_pins, .o_port_pins_oe, .o_alert_n, .o_alert_n_oe);
`default_nettype wire
